//--- pkg/cbi_consts.vh
// Constants for the clock buffer two-wire configuration port
`ifndef CBI_CONSTS_VH
`define CBI_CONSTS_VH
// ----------------------------------------
// Slave address and register map
// ----------------------------------------
`define CBI_ADDR_UPPER 6'h36
`define CBI_OFS_REF_SEL 4'h0
`define CBI_OFS_BANK_PWR 4'h1
`define CBI_REF_SEL_RESET 8'h00
`define CBI_BANK_PWR_RESET 8'h00
`define CBI_REG_DEPTH 16
// ----------------------------------------
// Field positions, offset 0
// ----------------------------------------
`define CBI_BIT_SWITCHOVER_STYLE 7
`define CBI_BIT_REF_SEL_HI 6
`define CBI_BIT_REF_SEL_LO 5
`define CBI_BIT_SEL_SOURCE 4
`define CBI_BIT_DIV_SYNC 0
// ----------------------------------------
// Field positions, offset 1
// ----------------------------------------
`define CBI_BIT_BANK_A_SUPPLY_HINT 7
`define CBI_BIT_BANK_B_SUPPLY_HINT 6
`define CBI_BIT_BANK_A_GLITCHFREE_DISABLE 5
`define CBI_BIT_BANK_B_GLITCHFREE_DISABLE 4
`define CBI_BIT_BANK_A_POWER_OFF 3
`define CBI_BIT_BANK_B_POWER_OFF 2
`define CBI_BIT_BANK_A_DIVIDER_OFF 1
`define CBI_BIT_BANK_B_DIVIDER_OFF 0
`endif

//--- design/cbi_regmem.v
// Sixteen byte register store with registered read data
`include "cbi_consts.vh"
module cbi_regmem (
  input wire mclk,
  input wire rst_n,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [3:0] rd_addr,
  output reg [7:0] rd_data_ff
);
  reg [7:0] mem [0:15];
  integer i;

  // ----------------------------------------
  // Storage, power-up defaults all zero
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < `CBI_REG_DEPTH; i = i + 1)
        mem[i] <= 8'h00;
      rd_data_ff <= 8'h00;
    end
    else
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      // Bypass so a read right after a write sees the new byte
      rd_data_ff <= (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
    end
  end
endmodule

//--- design/cbi_top.v
// Two-wire slave configuration port with device control outputs
`include "cbi_consts.vh"
module cbi_top (
  input wire mclk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_ff,
  output reg sda_oe_ff,
  input wire address_select_pin,
  input wire ref_select_pin,
  output reg switchover_style_ff,
  output reg div_a_from_input_1_ff,
  output reg div_b_from_input_1_ff,
  output reg dividers_held_ff,
  output reg dividers_realign_ff,
  output reg bank_a_supply_hint_ff,
  output reg bank_b_supply_hint_ff,
  output reg bank_a_glitchfree_disable_ff,
  output reg bank_b_glitchfree_disable_ff,
  output reg bank_a_power_off_ff,
  output reg bank_b_power_off_ff,
  output reg bank_a_divider_off_ff,
  output reg bank_b_divider_off_ff
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_WRX = 3'h3;
  localparam ST_RDX = 3'h4;
  localparam ST_RACK = 3'h5;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0] scl_sync_ff, sda_sync_ff, asel_sync_ff, rsel_sync_ff;
  reg scl_d_ff, sda_d_ff;
  wire scl = scl_sync_ff[1];
  wire sda = sda_sync_ff[1];
  wire scl_rise = scl & ~scl_d_ff;
  wire scl_fall = ~scl & scl_d_ff;
  wire start_cond = scl & scl_d_ff & sda_d_ff & ~sda;
  wire stop_cond = scl & scl_d_ff & ~sda_d_ff & sda;

  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      asel_sync_ff <= 2'h0;
      rsel_sync_ff <= 2'h0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      asel_sync_ff <= {asel_sync_ff[0], address_select_pin};
      rsel_sync_ff <= {rsel_sync_ff[0], ref_select_pin};
      scl_d_ff <= scl;
      sda_d_ff <= sda;
    end
  end

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  reg [2:0] state_ff;
  reg [2:0] bitcnt_ff;
  reg [7:0] shift_ff;
  reg [3:0] ptr_ff;
  reg is_read_ff;
  reg have_ofs_ff;
  reg ack_me_ff;
  reg wr_en;
  reg [7:0] ctrl0_ff, ctrl1_ff;
  wire [7:0] rd_data;
  wire [7:0] shifted = {shift_ff[6:0], sda};

  // Pointer advance wraps inside the sixteen byte space
  function [3:0] ptr_inc;
    input [3:0] p;
    begin
      ptr_inc = p + 4'h1;
    end
  endfunction

  always @*
  begin
    wr_en = (state_ff == ST_WRX) && scl_rise && (bitcnt_ff == 3'h7) && have_ofs_ff;
  end

  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 4'h0;
      is_read_ff <= 1'b0;
      have_ofs_ff <= 1'b0;
      ack_me_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else if (stop_cond)
    begin
      // Stop at any bit; half-shifted bytes are simply dropped
      state_ff <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end
    else if (start_cond)
    begin
      // Start or repeated start; the pointer is kept for plain reads
      state_ff <= ST_ADDR;
      bitcnt_ff <= 3'h0;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          sda_oe_ff <= 1'b0;
        ST_ADDR:
          if (scl_rise)
          begin
            shift_ff <= shifted;
            bitcnt_ff <= bitcnt_ff + 3'h1;
            if (bitcnt_ff == 3'h7)
            begin
              // Slave-only match on fixed bits plus strap level
              ack_me_ff <= (shifted[7:1] == {`CBI_ADDR_UPPER, asel_sync_ff[1]});
              is_read_ff <= sda;
              have_ofs_ff <= 1'b0;
              state_ff <= ST_ACK;
            end
          end
        ST_ACK:
          if (scl_fall && !sda_oe_ff && !(is_read_ff && have_ofs_ff))
          begin
            // Drive ack low during the ninth clock; not after a master ack on reads
            if (ack_me_ff)
            begin
              sda_out_ff <= 1'b0;
              sda_oe_ff <= 1'b1;
            end
            else
              state_ff <= ST_IDLE;
          end
          else if (scl_fall)
          begin
            bitcnt_ff <= 3'h0;
            if (is_read_ff)
            begin
              // First data bit goes out right after the ack
              state_ff <= ST_RDX;
              shift_ff <= {rd_data[6:0], 1'b0};
              sda_out_ff <= rd_data[7];
              sda_oe_ff <= ~rd_data[7];
              ptr_ff <= ptr_inc(ptr_ff);
            end
            else
            begin
              state_ff <= ST_WRX;
              sda_oe_ff <= 1'b0;
            end
          end
        ST_WRX:
          if (scl_rise)
          begin
            shift_ff <= shifted;
            bitcnt_ff <= bitcnt_ff + 3'h1;
            if (bitcnt_ff == 3'h7)
            begin
              state_ff <= ST_ACK;
              have_ofs_ff <= 1'b1;
              // Offset byte loads pointer, data bytes advance it
              ptr_ff <= have_ofs_ff ? ptr_inc(ptr_ff) : shifted[3:0];
            end
          end
        ST_RDX:
          if (scl_fall)
          begin
            bitcnt_ff <= bitcnt_ff + 3'h1;
            if (bitcnt_ff == 3'h7)
            begin
              sda_oe_ff <= 1'b0;
              state_ff <= ST_RACK;
            end
            else
            begin
              // Open-drain: enable only to pull low
              sda_out_ff <= 1'b0;
              sda_oe_ff <= ~shift_ff[7];
              shift_ff <= {shift_ff[6:0], 1'b0};
            end
          end
        ST_RACK:
          if (scl_rise)
          begin
            // Master nack ends the block; an ack sends the next byte at once
            state_ff <= sda ? ST_IDLE : ST_ACK;
            ack_me_ff <= 1'b1;
            // On reads this flag marks a master ack, so no extra slave ack clock
            have_ofs_ff <= 1'b1;
          end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register store and device control shadows
  // ----------------------------------------
  // Read address is the pointer, so data are ready before the ack ends
  cbi_regmem u_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_addr(ptr_ff),
    .wr_data(shifted),
    .rd_addr(ptr_ff),
    .rd_data_ff(rd_data)
  );

  // Control bytes update on the eighth bit, before stop
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl0_ff <= `CBI_REF_SEL_RESET;
      ctrl1_ff <= `CBI_BANK_PWR_RESET;
    end
    else if (wr_en)
    begin
      if (ptr_ff == `CBI_OFS_REF_SEL)
        ctrl0_ff <= shifted; // reserved bits stored as written
      if (ptr_ff == `CBI_OFS_BANK_PWR)
        ctrl1_ff <= shifted;
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      switchover_style_ff <= 1'b0;
      div_a_from_input_1_ff <= 1'b0;
      div_b_from_input_1_ff <= 1'b0;
      dividers_held_ff <= 1'b0;
      dividers_realign_ff <= 1'b0;
      bank_a_supply_hint_ff <= 1'b0;
      bank_b_supply_hint_ff <= 1'b0;
      bank_a_glitchfree_disable_ff <= 1'b0;
      bank_b_glitchfree_disable_ff <= 1'b0;
      bank_a_power_off_ff <= 1'b0;
      bank_b_power_off_ff <= 1'b0;
      bank_a_divider_off_ff <= 1'b0;
      bank_b_divider_off_ff <= 1'b0;
    end
    else
    begin
      switchover_style_ff <= ctrl0_ff[`CBI_BIT_SWITCHOVER_STYLE];
      // Pin drives both dividers unless register selection is on
      div_a_from_input_1_ff <= ctrl0_ff[`CBI_BIT_SEL_SOURCE] ? ctrl0_ff[`CBI_BIT_REF_SEL_LO] : rsel_sync_ff[1];
      div_b_from_input_1_ff <= ctrl0_ff[`CBI_BIT_SEL_SOURCE] ? ctrl0_ff[`CBI_BIT_REF_SEL_HI] : rsel_sync_ff[1];
      dividers_held_ff <= ctrl0_ff[`CBI_BIT_DIV_SYNC];
      // One-cycle pulse on release so both dividers restart together
      dividers_realign_ff <= dividers_held_ff & ~ctrl0_ff[`CBI_BIT_DIV_SYNC];
      bank_a_supply_hint_ff <= ctrl1_ff[`CBI_BIT_BANK_A_SUPPLY_HINT];
      bank_b_supply_hint_ff <= ctrl1_ff[`CBI_BIT_BANK_B_SUPPLY_HINT];
      bank_a_glitchfree_disable_ff <= ctrl1_ff[`CBI_BIT_BANK_A_GLITCHFREE_DISABLE];
      bank_b_glitchfree_disable_ff <= ctrl1_ff[`CBI_BIT_BANK_B_GLITCHFREE_DISABLE];
      bank_a_power_off_ff <= ctrl1_ff[`CBI_BIT_BANK_A_POWER_OFF];
      bank_b_power_off_ff <= ctrl1_ff[`CBI_BIT_BANK_B_POWER_OFF];
      bank_a_divider_off_ff <= ctrl1_ff[`CBI_BIT_BANK_A_DIVIDER_OFF];
      bank_b_divider_off_ff <= ctrl1_ff[`CBI_BIT_BANK_B_DIVIDER_OFF];
    end
  end
endmodule

//--- tb/cbi_sva.sv
// Concurrent checks on the configuration port pins and control outputs
module cbi_sva (
  input wire mclk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out_ff,
  input wire sda_oe_ff,
  input wire switchover_style_ff,
  input wire dividers_held_ff,
  input wire dividers_realign_ff,
  input wire bank_a_power_off_ff,
  input wire bank_b_divider_off_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Stop on the pins: data rises while the clock stays high
  sequence s_stop;
    $rose(sda_in) && scl_in && $past(scl_in);
  endsequence
  // Realign pulse rises in the same cycle as the hold output drops
  a_realign_after_fall: assert property ($fell(dividers_held_ff) |-> dividers_realign_ff)
    else $error("realign pulse missing after hold release");
  a_realign_cause: assert property (dividers_realign_ff |-> $fell(dividers_held_ff))
    else $error("realign pulse without hold release");
  a_sda_open_drain: assert property (sda_oe_ff |-> !sda_out_ff)
    else $error("data line driven high");
  // Moving data under a high clock would read as start or stop
  a_sda_moves_low: assert property ($changed(sda_oe_ff) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed while clock high");
  a_sda_stable_high: assert property ($rose(scl_in) |=> $stable(sda_oe_ff) [*8])
    else $error("data drive unstable after clock rise");
  a_idle_after_stop: assert property (s_stop |=> !sda_oe_ff [*8])
    else $error("data driven after stop");
  a_drive_bounded: assert property ($rose(sda_oe_ff) |-> ##[1:1000] !sda_oe_ff)
    else $error("data line held low too long");
  a_ctrl_on_byte: assert property ($changed({switchover_style_ff, dividers_held_ff, bank_a_power_off_ff,
    bank_b_divider_off_ff}) |-> scl_in && $past(scl_in) && !sda_oe_ff)
    else $error("control output changed outside a received bit");
  // Main scenarios reached
  c_realign: cover property (dividers_realign_ff);
  c_stop: cover property (s_stop);
  c_drive: cover property ($rose(sda_oe_ff));
endmodule
bind cbi_top cbi_sva i_sva (.mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff),
  .sda_oe_ff(sda_oe_ff), .switchover_style_ff(switchover_style_ff), .dividers_held_ff(dividers_held_ff),
  .dividers_realign_ff(dividers_realign_ff), .bank_a_power_off_ff(bank_a_power_off_ff),
  .bank_b_divider_off_ff(bank_b_divider_off_ff));

//--- tb/cbi_master.sv
// Behavioural two-wire bus master facing the configuration port
module cbi_master (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // Quarter bit of 25 cycles keeps the bus at 400 kHz, no faster
  localparam int Q = 25;
  // Idle bus: both lines released to the pull-ups
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Inputs move one step after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(2 * Q);
    sda_low = 1'b1;
    tick(2 * Q);
    scl = 1'b0;
    tick(Q);
  endtask
  // Stop normally follows a whole byte; the bench may cut one short
  task automatic stop();
    sda_low = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(2 * Q);
    sda_low = 1'b0;
    tick(2 * Q);
  endtask
  // One clock pulse, data set mid-low and sampled mid-high
  task automatic sbit(input logic b, output logic r);
    sda_low = ~b;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    r = sda;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask
  // Eight bits most significant first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic n);
    for (int i = 7; i >= 0; i--)
      sbit(d[i], r[i]);
    sbit(a, n);
  endtask
endmodule

//--- tb/cbi_top_tb_top.sv
// Self-checking bench for the two-wire configuration port
`include "cbi_consts.vh"
module cbi_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic pin = 1'b0;
  logic scl;
  logic sda_low;
  logic oe;
  logic [3:0] ctl;
  logic [7:0] bank;
  integer seed = 32'h09b82373;
  int num_errors = 0;
  int checked = 0;
  // Pulled-up data wire, low when either side pulls
  wire sda = !(sda_low || oe);
  always #12.5 mclk = ~mclk;
  cbi_master i_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  cbi_top i_dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out_ff(), .sda_oe_ff(oe),
    .address_select_pin(strap), .ref_select_pin(pin), .switchover_style_ff(ctl[3]),
    .div_a_from_input_1_ff(ctl[2]), .div_b_from_input_1_ff(ctl[1]), .dividers_held_ff(ctl[0]),
    .dividers_realign_ff(), .bank_a_supply_hint_ff(bank[7]), .bank_b_supply_hint_ff(bank[6]),
    .bank_a_glitchfree_disable_ff(bank[5]), .bank_b_glitchfree_disable_ff(bank[4]),
    .bank_a_power_off_ff(bank[3]), .bank_b_power_off_ff(bank[2]), .bank_a_divider_off_ff(bank[1]),
    .bank_b_divider_off_ff(bank[0]));
  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  // Register selection only when the source bit is set, else the pin
  function automatic logic [7:0] ctl_exp(input logic [7:0] b, input logic p);
    return {4'h0, b[7], b[4] ? b[5] : p, b[4] ? b[6] : p, b[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Block write of offsets 0 and 1, outputs checked before the stop
  task automatic wr2(input logic [7:0] b0, input logic [7:0] b1);
    logic [7:0] r;
    logic n;
    i_mst.start();
    i_mst.xfer({`CBI_ADDR_UPPER, strap, 1'b0}, 1'b1, r, n);
    i_mst.xfer(8'h00, 1'b1, r, n);
    i_mst.xfer(b0, 1'b1, r, n);
    chk({4'h0, ctl[3:0]}, ctl_exp(b0, pin));
    i_mst.xfer(b1, 1'b1, r, n);
    chk(bank, b1);
    chk({7'h0, n}, 8'h00);
    i_mst.stop();
  endtask
  // Read address, two bytes, master refuses the last one
  task automatic rd_tail(output logic [7:0] r0, output logic [7:0] r1);
    logic n;
    i_mst.xfer({`CBI_ADDR_UPPER, strap, 1'b1}, 1'b1, r0, n);
    chk({7'h0, n}, 8'h00);
    i_mst.xfer(8'hFF, 1'b0, r0, n);
    i_mst.xfer(8'hFF, 1'b1, r1, n);
    i_mst.stop();
  endtask
  task automatic rd2(output logic [7:0] r0, output logic [7:0] r1);
    logic n;
    i_mst.start();
    i_mst.xfer({`CBI_ADDR_UPPER, strap, 1'b0}, 1'b1, r0, n);
    i_mst.xfer(8'h00, 1'b1, r0, n);
    i_mst.start();
    rd_tail(r0, r1);
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial
  begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] r0;
    logic [7:0] r1;
    logic n;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    i_mst.tick(4);
    chk({4'h0, ctl}, 8'h00);
    i_mst.start();
    rd_tail(r0, r1);
    chk(r0, 8'h00);
    chk(r1, 8'h00);
    // Other strap level must be ignored
    i_mst.start();
    i_mst.xfer({`CBI_ADDR_UPPER, ~strap, 1'b0}, 1'b1, r0, n);
    chk({7'h0, n}, 8'h01);
    i_mst.stop();
    // Every select code first, then random bytes; hold bit toggles
    for (int i = 0; i < 6; i++)
    begin
      b0 = $random(seed);
      b1 = $random(seed);
      if (i < 4)
        b0[6:4] = {i[1:0], 1'b1};
      b0[3:0] = {3'h0, i[0]};
      pin = b1[0];
      wr2(b0, b1);
      rd2(r0, r1);
      chk(r0, b0);
      chk(r1, b1);
      pin = ~pin;
      i_mst.tick(6);
      chk({4'h0, ctl}, ctl_exp(b0, pin));
    end
    // Stop after half a byte leaves offset 1 untouched
    i_mst.start();
    i_mst.xfer({`CBI_ADDR_UPPER, strap, 1'b0}, 1'b1, r0, n);
    i_mst.xfer(8'h01, 1'b1, r0, n);
    repeat (4) i_mst.sbit(~b1[0], n);
    i_mst.stop();
    chk(bank, b1);
    strap = 1'b1;
    i_mst.tick(4);
    rd2(r0, r1);
    chk(r1, b1);
    tally_and_finish();
  end
endmodule
